// *** rtl/sfe_defs.svh ***
// register offsets, field positions, reset values and sizes of the serial error block
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_IRQ_EN 12'h008
`define ADDR_TX_SLOT 12'h00C
`define ADDR_RX_SLOT 12'h010
`define ADDR_CD_SLOT 12'h014
`define ADDR_TX_DATA 12'h018
`define ADDR_RX_DATA 12'h01C
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define FLAG_SLOT 5
`define FLAG_FSYNC 4
`define FLAG_TX_OVF 3
`define FLAG_TX_UDF 2
`define FLAG_RX_UDF 1
`define FLAG_RX_OVF 0
`define FLAGS_W 6
`define FLAGS_RESET 6'h00
`define SLOT_VALID_BIT 7
`define SLOT_W 4
`define WORD_W 16
`define FIFO_DEPTH 32
`endif

// *** rtl/sfe_pkg.sv ***
// types shared by the serial error block
`include "sfe_defs.svh"
package sfe_pkg;
    typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic tx_en;
        logic rx_en;
        logic [`FLAGS_W-1:0] flags;
        logic [`FLAGS_W-1:0] irq_en;
        logic [7:0] tx_slot;
        logic [7:0] rx_slot;
        logic [7:0] cd_slot;
        logic irq;
        link_state_t link;
        logic sck_prev;
        logic fs_prev;
        logic [3:0] bit_cnt;
        logic [`SLOT_W-1:0] slot_cnt;
        logic [`WORD_W-1:0] tx_shift;
        logic [`WORD_W-1:0] tx_last;
        logic [`WORD_W-1:0] rx_shift;
        logic tx_pin;
    } port_state_t;
endpackage : sfe_pkg

// *** rtl/sfe_bit_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module sfe_bit_sync #(parameter int W = 3) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;
    sync_state_t q;
    sync_state_t d;

    // the first stage feeds only the second one
    always_comb begin
        d = q;
        d.s1 = i_async;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;
endmodule : sfe_bit_sync

// *** rtl/sfe_fifo.sv ***
// first-word-fall-through fifo with registered read data
`timescale 1ns/1ns
module sfe_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 32) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] count;
        logic [WIDTH-1:0] out_data;
        logic out_valid;
    } fifo_state_t;
    fifo_state_t q;
    fifo_state_t d;
    logic push;
    logic pop;

    // depth must be a power of two: pointers wrap by overflow
    always_comb begin
        d = q;
        push = i_valid && (q.count != CW'(DEPTH));
        pop = i_ready && q.out_valid;
        if (push) begin
            d.mem[q.wr] = i_data;
            d.wr = q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = q.rd + AW'(1);
        end
        d.count = q.count + CW'(push) - CW'(pop);
        d.out_valid = (d.count != '0);
        // reading the next memory image keeps a same-cycle push visible
        d.out_data = d.mem[d.rd];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_ready = (q.count != CW'(DEPTH));
    assign o_valid = q.out_valid;
    assign o_data = q.out_data;
endmodule : sfe_fifo

// *** rtl/serial_fifo_error_flags.sv ***
// framed serial port with fifos, sticky error flags and apb registers
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "sfe_defs.svh"
module serial_fifo_error_flags #(parameter int FIFO_DEPTH = `FIFO_DEPTH) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_link_sck,
    input wire logic i_frame_sync,
    input wire logic i_serial_rx_pin,
    output logic o_serial_tx_pin,
    output logic o_irq
);
    sfe_pkg::port_state_t q;
    sfe_pkg::port_state_t d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [2:0] pins_s;
    logic sck_s;
    logic fs_s;
    logic rx_s;
    logic sck_rise;
    logic sck_fall;
    logic fs_start;
    logic access;
    logic en_any;
    logic overlap;
    logic tx_now;
    logic rx_now;
    logic [`FLAGS_W-1:0] set_ev;
    logic [`FLAGS_W-1:0] clr;
    logic [`WORD_W-1:0] word;
    logic tx_push;
    logic tx_in_ready;
    logic tx_pop;
    logic tx_out_valid;
    logic [`WORD_W-1:0] tx_out_data;
    logic rx_push;
    logic [`WORD_W-1:0] rx_word;
    logic rx_in_ready;
    logic rx_pop;
    logic rx_out_valid;
    logic [`WORD_W-1:0] rx_out_data;

    function automatic logic slot_hit(input logic [7:0] s, input logic [`SLOT_W-1:0] n);
        slot_hit = s[`SLOT_VALID_BIT] && (s[`SLOT_W-1:0] == n);
    endfunction : slot_hit

    function automatic logic slot_overlap(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c);
        slot_overlap = slot_hit(a, b[`SLOT_W-1:0]) && b[`SLOT_VALID_BIT] ||
                       slot_hit(a, c[`SLOT_W-1:0]) && c[`SLOT_VALID_BIT] ||
                       slot_hit(b, c[`SLOT_W-1:0]) && c[`SLOT_VALID_BIT];
    endfunction : slot_overlap

    // the frame is over once the highest assigned slot has passed
    function automatic logic [`SLOT_W-1:0] last_slot(input logic [7:0] a, input logic [7:0] b,
                                                     input logic [7:0] c);
        logic [`SLOT_W-1:0] m;
        m = '0;
        if (a[`SLOT_VALID_BIT] && a[`SLOT_W-1:0] > m) m = a[`SLOT_W-1:0];
        if (b[`SLOT_VALID_BIT] && b[`SLOT_W-1:0] > m) m = b[`SLOT_W-1:0];
        if (c[`SLOT_VALID_BIT] && c[`SLOT_W-1:0] > m) m = c[`SLOT_W-1:0];
        last_slot = m;
    endfunction : last_slot

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    sfe_bit_sync #(.W(3)) pin_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_async({i_link_sck, i_frame_sync, i_serial_rx_pin}),
        .o_sync(pins_s)
    );
    assign sck_s = pins_s[2];
    assign fs_s = pins_s[1];
    assign rx_s = pins_s[0];

    sfe_fifo #(.WIDTH(`WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_valid(tx_push),
        .i_data(i_pwdata[`WORD_W-1:0]),
        .o_ready(tx_in_ready),
        .o_valid(tx_out_valid),
        .o_data(tx_out_data),
        .i_ready(tx_pop)
    );

    sfe_fifo #(.WIDTH(`WORD_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_valid(rx_push),
        .i_data(rx_word),
        .o_ready(rx_in_ready),
        .o_valid(rx_out_valid),
        .o_data(rx_out_data),
        .i_ready(rx_pop)
    );

    always_comb begin
        d = q;
        set_ev = '0;
        clr = '0;
        word = q.tx_last;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        rx_word = '0;
        sck_rise = sck_s && !q.sck_prev;
        sck_fall = !sck_s && q.sck_prev;
        fs_start = sck_rise && fs_s && !q.fs_prev;
        en_any = q.tx_en || q.rx_en;
        overlap = slot_overlap(q.tx_slot, q.rx_slot, q.cd_slot);
        tx_now = q.tx_en && slot_hit(q.tx_slot, q.slot_cnt);
        rx_now = q.rx_en && slot_hit(q.rx_slot, q.slot_cnt);
        // one wait state: pready rises in the first access cycle's edge
        access = i_psel && i_penable && !q.pready;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.sck_prev = sck_s;
        set_ev[`FLAG_SLOT] = overlap && en_any;
        if (access) begin
            d.pready = 1'b1;
            d.prdata = '0;
            case (i_paddr)
                `ADDR_CTRL: begin
                    if (i_pwrite) begin
                        d.tx_en = i_pwdata[`CTRL_TX_EN];
                        d.rx_en = i_pwdata[`CTRL_RX_EN];
                    end
                    d.prdata[`CTRL_TX_EN] = q.tx_en;
                    d.prdata[`CTRL_RX_EN] = q.rx_en;
                end
                `ADDR_STATUS: begin
                    if (i_pwrite) clr = i_pwdata[`FLAGS_W-1:0];
                    d.prdata[`FLAGS_W-1:0] = q.flags;
                end
                `ADDR_IRQ_EN: begin
                    if (i_pwrite) d.irq_en = i_pwdata[`FLAGS_W-1:0];
                    d.prdata[`FLAGS_W-1:0] = q.irq_en;
                end
                `ADDR_TX_SLOT: begin
                    if (i_pwrite) d.tx_slot = i_pwdata[7:0];
                    d.prdata[7:0] = q.tx_slot;
                end
                `ADDR_RX_SLOT: begin
                    if (i_pwrite) d.rx_slot = i_pwdata[7:0];
                    d.prdata[7:0] = q.rx_slot;
                end
                `ADDR_CD_SLOT: begin
                    if (i_pwrite) d.cd_slot = i_pwdata[7:0];
                    d.prdata[7:0] = q.cd_slot;
                end
                `ADDR_TX_DATA: begin
                    tx_push = i_pwrite;
                    set_ev[`FLAG_TX_OVF] = i_pwrite && !tx_in_ready && q.tx_en;
                end
                `ADDR_RX_DATA: begin
                    rx_pop = !i_pwrite;
                    if (rx_out_valid) begin
                        d.prdata[`WORD_W-1:0] = rx_out_data;
                    end
                    set_ev[`FLAG_RX_UDF] = !i_pwrite && !rx_out_valid && q.rx_en;
                end
                default: d.pslverr = 1'b1;
            endcase
        end
        if (sck_rise) begin
            d.fs_prev = fs_s;
        end
        if (fs_start) begin
            // an early sync restarts the frame so later slots still move
            set_ev[`FLAG_FSYNC] = (q.link == sfe_pkg::LINK_FRAME) && en_any;
            d.link = sfe_pkg::LINK_FRAME;
            d.bit_cnt = 4'h0;
            d.slot_cnt = '0;
        end else if (sck_rise && q.link == sfe_pkg::LINK_FRAME) begin
            if (rx_now && !overlap) begin
                d.rx_shift = {q.rx_shift[`WORD_W-2:0], rx_s};
                if (q.bit_cnt == 4'hF) begin
                    rx_push = 1'b1;
                    rx_word = d.rx_shift;
                    set_ev[`FLAG_RX_OVF] = !rx_in_ready;
                end
            end
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == 4'hF) begin
                d.slot_cnt = q.slot_cnt + `SLOT_W'(1);
                if (q.slot_cnt == last_slot(q.tx_slot, q.rx_slot, q.cd_slot)) begin
                    d.link = sfe_pkg::LINK_IDLE;
                end
            end
        end
        if (sck_fall && q.link == sfe_pkg::LINK_FRAME && tx_now && !overlap) begin
            if (q.bit_cnt == 4'h0) begin
                tx_pop = 1'b1;
                if (tx_out_valid) word = tx_out_data;
                set_ev[`FLAG_TX_UDF] = !tx_out_valid;
                d.tx_last = word;
                d.tx_pin = word[`WORD_W-1];
                d.tx_shift = {word[`WORD_W-2:0], 1'b0};
            end else begin
                d.tx_pin = q.tx_shift[`WORD_W-1];
                d.tx_shift = {q.tx_shift[`WORD_W-2:0], 1'b0};
            end
        end else if (sck_fall || overlap) begin
            d.tx_pin = 1'b0;
        end
        d.flags = (q.flags & ~clr) | set_ev;
        d.irq = |(d.flags & d.irq_en);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_pready = q.pready;
    assign o_prdata = q.prdata;
    assign o_pslverr = q.pslverr;
    assign o_serial_tx_pin = q.tx_pin;
    assign o_irq = q.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    a_slot_err_set: assert property (overlap && en_any |=> q.flags[`FLAG_SLOT])
        else $error("slot error flag not set on overlap");
    a_slot_pin_quiet: assert property (overlap |=> !o_serial_tx_pin)
        else $error("tx pin driven during slot error");
    a_slot_keeps_en: assert property (
        overlap && !(access && i_pwrite && i_paddr == `ADDR_CTRL)
        |=> $stable(q.tx_en) && $stable(q.rx_en))
        else $error("enables changed by slot error");
    a_fsync_err_set: assert property (
        fs_start && q.link == sfe_pkg::LINK_FRAME && en_any |=> q.flags[`FLAG_FSYNC])
        else $error("frame sync error flag not set");
    a_fsync_restart: assert property (
        fs_start |=> q.link == sfe_pkg::LINK_FRAME && q.slot_cnt == `SLOT_W'(0)
        && q.bit_cnt == 4'h0)
        else $error("frame not restarted on sync");
    // a pop in the same cycle frees a place, so only a fifo that stays full is checked
    a_tx_ovf_set: assert property (
        access && i_pwrite && i_paddr == `ADDR_TX_DATA && !tx_in_ready && q.tx_en && !tx_pop
        |=> q.flags[`FLAG_TX_OVF] && !tx_in_ready)
        else $error("tx overflow not flagged");
    a_tx_udf_repeat: assert property (
        tx_pop && !tx_out_valid |=> q.flags[`FLAG_TX_UDF] && q.tx_last == $past(q.tx_last))
        else $error("tx underflow handling wrong");
    a_rx_udf_set: assert property (
        access && !i_pwrite && i_paddr == `ADDR_RX_DATA && !rx_out_valid && q.rx_en
        |=> q.flags[`FLAG_RX_UDF])
        else $error("rx underflow not flagged");
    a_rx_ovf_set: assert property (rx_push && !rx_in_ready |=> q.flags[`FLAG_RX_OVF])
        else $error("rx overflow not flagged");
    a_zero_write_keeps: assert property (
        access && i_pwrite && i_paddr == `ADDR_STATUS && i_pwdata[`FLAGS_W-1:0] == `FLAGS_RESET
        |=> ($past(q.flags) & ~q.flags) == 6'h00)
        else $error("flag cleared by zero write");
    a_flags_idle: assert property (
        !q.tx_en && !q.rx_en |=> (q.flags & ~$past(q.flags)) == 6'h00)
        else $error("flag set while port disabled");
    a_irq_follows: assert property (o_irq == |(q.flags & q.irq_en))
        else $error("interrupt does not match flags and enables");
    a_set_beats_clr: assert property (
        overlap && en_any && access && i_pwrite && i_paddr == `ADDR_STATUS
        && i_pwdata[`FLAG_SLOT] |=> q.flags[`FLAG_SLOT]
        ##1 (o_irq || !$past(q.irq_en[`FLAG_SLOT])))
        else $error("clear won over a new error");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
endmodule : serial_fifo_error_flags

// *** sim/sfe_codec_model.sv ***
// behavioural far-side codec: makes link clock and sync, sends rx slot, captures tx slot
`timescale 1ns/1ns
module sfe_codec_model (
    input wire logic i_start,
    input wire logic [15:0] i_rx_word,
    input wire logic [5:0] i_early,
    input wire logic i_tx_pin,
    output logic o_sck,
    output logic o_fs,
    output logic o_rx,
    output logic o_busy,
    output logic [15:0] o_tx_word
);
    // link clock stands low outside frames
    initial begin
        o_sck = 1'b0;
        o_fs = 1'b0;
        o_rx = 1'b0;
        o_busy = 1'b0;
        o_tx_word = 16'h0000;
    end

    // one frame: rise 0 carries sync, tx slot 0 is rises 1..16, rx slot 1 is rises 17..32
    always @(posedge i_start) begin : frame
        int r;
        logic again;
        o_busy = 1'b1;
        again = 1'b0;
        r = 0;
        // start off the system clock edge so the pins never change as it samples
        #20 o_fs = 1'b1;
        while (r <= 32) begin
            #400 o_sck = 1'b1;
            if (r >= 1 && r <= 16) begin
                o_tx_word[16-r] = i_tx_pin;
            end
            #400 o_sck = 1'b0;
            o_fs = 1'b0;
            // outside the rx slot the line carries no value, so it keeps toggling
            if (r >= 16 && r < 32) begin
                o_rx = i_rx_word[31-r];
            end else begin
                o_rx = ~o_rx;
            end
            r++;
            if (i_early != 6'h00 && r == i_early && !again) begin
                o_fs = 1'b1;
                r = 0;
                again = 1'b1;
            end
        end
        o_busy = 1'b0;
    end
endmodule : sfe_codec_model

// *** sim/serial_fifo_error_flags_tb_top.sv ***
// self-checking bench for the serial error flag block
`timescale 1ns/1ns
`include "sfe_defs.svh"
module serial_fifo_error_flags_tb_top;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, perr, err, sck, fs, rxp, txp, irq, busy;
    logic start = 1'b0;
    logic [15:0] rxw = 16'h0000;
    logic [15:0] txw;
    logic [5:0] early = 6'h00;
    int error_cnt = 0;
    int n_tests = 0;

    always #50 i_clk = ~i_clk;

    // small fifo so that full and empty are reached in a few frames
    serial_fifo_error_flags #(.FIFO_DEPTH(4)) serial_fifo_error_flags_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(perr), .i_link_sck(sck), .i_frame_sync(fs),
        .i_serial_rx_pin(rxp), .o_serial_tx_pin(txp), .o_irq(irq));

    sfe_codec_model sfe_codec_model_i (
        .i_start(start), .i_rx_word(rxw), .i_early(early), .i_tx_pin(txp),
        .o_sck(sck), .o_fs(fs), .o_rx(rxp), .o_busy(busy), .o_tx_word(txw));

    task stop_test;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        k = 0;
        // values read right after the edge are the ones the edge sampled
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task chk_irq(input logic exp);
        @(negedge i_clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    task run_frame(input logic [15:0] w, input logic [5:0] e);
        int k;
        @(posedge i_clk);
        rxw <= w;
        early <= e;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge i_clk);
            k++;
        end
        if (busy !== 1'b0) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        // let the synchronised last rise reach the fifo
        repeat (10) @(posedge i_clk);
    endtask : run_frame

    task t_reset;
        rdc(`ADDR_CTRL, 32'h0);
        rdc(`ADDR_STATUS, 32'h0);
        rdc(`ADDR_IRQ_EN, 32'h0);
        rdc(12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset

    task t_rx_udf;
        apb(1'b0, `ADDR_RX_DATA, 32'h0);
        rdc(`ADDR_STATUS, 32'h0);
        apb(1'b1, `ADDR_CTRL, 32'h2);
        apb(1'b0, `ADDR_RX_DATA, 32'h0);
        rdc(`ADDR_STATUS, 32'h2);
    endtask : t_rx_udf

    task t_tx_ovf;
        apb(1'b1, `ADDR_CTRL, 32'h3);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `ADDR_TX_DATA, 32'hA000 + i);
        end
        rdc(`ADDR_STATUS, 32'hA);
    endtask : t_tx_ovf

    task t_w1c_irq;
        apb(1'b1, `ADDR_IRQ_EN, 32'h2);
        chk_irq(1'b1);
        apb(1'b1, `ADDR_STATUS, 32'h0);
        rdc(`ADDR_STATUS, 32'hA);
        apb(1'b1, `ADDR_STATUS, 32'h8);
        rdc(`ADDR_STATUS, 32'h2);
        apb(1'b1, `ADDR_IRQ_EN, 32'h8);
        chk_irq(1'b0);
        apb(1'b1, `ADDR_IRQ_EN, 32'h3F);
        chk_irq(1'b1);
        apb(1'b1, `ADDR_STATUS, 32'h2);
        chk_irq(1'b0);
    endtask : t_w1c_irq

    task t_frames;
        apb(1'b1, `ADDR_TX_SLOT, 32'h80);
        apb(1'b1, `ADDR_RX_SLOT, 32'h81);
        apb(1'b1, `ADDR_CD_SLOT, 32'h00);
        for (int i = 0; i < 5; i++) begin
            run_frame(16'hC000 + i, 6'h00);
            chk({16'h0, txw}, (i < 4) ? 32'hA000 + i : 32'hA003);
        end
        rdc(`ADDR_STATUS, 32'h5);
        for (int i = 0; i < 4; i++) begin
            rdc(`ADDR_RX_DATA, 32'hC000 + i);
        end
        rdc(`ADDR_STATUS, 32'h5);
        apb(1'b1, `ADDR_STATUS, 32'h5);
    endtask : t_frames

    task t_fsync;
        run_frame(16'h5A5A, 6'h0A);
        rdc(`ADDR_STATUS, 32'h14);
        chk({16'h0, txw}, 32'hA003);
        rdc(`ADDR_RX_DATA, 32'h5A5A);
        apb(1'b1, `ADDR_STATUS, 32'h14);
    endtask : t_fsync

    task t_slot;
        apb(1'b1, `ADDR_RX_SLOT, 32'h80);
        rdc(`ADDR_STATUS, 32'h20);
        chk_irq(1'b1);
        rdc(`ADDR_CTRL, 32'h3);
        apb(1'b1, `ADDR_TX_DATA, 32'hFFFF);
        run_frame(16'h3C3C, 6'h00);
        chk({16'h0, txw}, 32'h0);
        apb(1'b0, `ADDR_RX_DATA, 32'h0);
        rdc(`ADDR_STATUS, 32'h22);
        // overlap still present, so the clear of the slot flag cannot stick
        apb(1'b1, `ADDR_STATUS, 32'h22);
        rdc(`ADDR_STATUS, 32'h20);
        apb(1'b1, `ADDR_RX_SLOT, 32'h81);
        apb(1'b1, `ADDR_STATUS, 32'h20);
        rdc(`ADDR_STATUS, 32'h0);
        apb(1'b1, `ADDR_CD_SLOT, 32'h81);
        rdc(`ADDR_STATUS, 32'h20);
        apb(1'b1, `ADDR_CD_SLOT, 32'h00);
        apb(1'b1, `ADDR_STATUS, 32'h20);
        rdc(`ADDR_STATUS, 32'h0);
        chk_irq(1'b0);
    endtask : t_slot

    initial begin
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset();
        t_rx_udf();
        t_tx_ovf();
        t_w1c_irq();
        t_frames();
        t_fsync();
        t_slot();
        stop_test();
    end
endmodule : serial_fifo_error_flags_tb_top
